// >>> estr_pkg.sv
// Shared constants for the speed/torque override command link.
// Assumes one clock domain and fixed eight-byte command frames.
package estr_pkg;
  localparam int  CLK_MHZ         = 125;
  localparam int  WDOG_MS         = 30;
  localparam int  WDOG_CYCLES     = WDOG_MS * 1000 * CLK_MHZ;
  localparam int  FRAME_BYTES     = 8;
  localparam logic [7:0] DEST_ENGINE = 8'h00;
  localparam logic [7:0] NODE_ADDR   = 8'h00;
  localparam int  MODE_LSB        = 0;
  localparam int  PRIO_LSB        = 4;
  localparam int  SPEED_LO_BYTE   = 1;
  localparam int  SPEED_HI_BYTE   = 2;
  localparam int  TORQUE_BYTE     = 3;
  localparam logic [15:0] SPEED_MAX_RAW = 16'hFB00;
  localparam logic [7:0]  TORQUE_OFFSET = 8'h7D;
  localparam logic [7:0]  TORQUE_MAX_RAW = 8'hFA;
  localparam logic [1:0]  PRIO_RESET     = 2'h3;
  localparam logic [15:0] SPEED_RESET    = 16'h0000;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [31:0] WORD_RESET     = 32'h0000_0000;

  // APB register offsets of the commanding controller.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SPEED  = 8'h04;
  localparam logic [7:0] A_TORQUE = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0C;
  localparam logic [7:0] A_IEN    = 8'h10;
  localparam logic [7:0] A_ICLR   = 8'h14;
  localparam logic [7:0] A_SRC    = 8'h18;
  localparam int CTRL_SEND   = 0;
  localparam int CTRL_MODE   = 1;
  localparam int CTRL_PRIO   = 3;
  localparam int ST_SENT     = 0;
  localparam int ST_BUSY     = 1;
  localparam int N_IRQ       = 1;

  typedef enum logic [1:0] {
    ESTR_MODE_OFF    = 2'b00,
    ESTR_MODE_SPEED  = 2'b01,
    ESTR_MODE_TORQUE = 2'b10,
    ESTR_MODE_LIMIT  = 2'b11
  } estr_mode_e;

  typedef enum logic [1:0] {
    ESTR_OV_LOCAL   = 2'b00,
    ESTR_OV_NET     = 2'b01,
    ESTR_OV_TIMEOUT = 2'b10,
    ESTR_OV_RELEASE = 2'b11
  } estr_ov_e;
endpackage

// >>> estr_if.sv
// Frame link between the commanding controller and the engine receiver.
// Assumes frames arrive whole, one byte per valid cycle, from a CAN MAC.
`timescale 1ns/100ps
interface estr_if;
  logic       frame_start;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic [7:0] dest_addr;
  logic [7:0] src_addr;
  logic       byte_ready;

  modport sender (
    output frame_start,
    output byte_valid,
    output byte_data,
    output dest_addr,
    output src_addr,
    input  byte_ready
  );
  modport engine (
    input  frame_start,
    input  byte_valid,
    input  byte_data,
    input  dest_addr,
    input  src_addr,
    output byte_ready
  );
endinterface

// >>> estr_engine_rx.sv
// Engine side receiver and interpreter of speed_torque_override_command.
// Assumes an upstream MAC delivers frames on the link interface.
//
// Summary of operation
// RL1 - Decode two-bit mode field of byte one.
// RL2 - Speed from bytes two, three at 0.125 rpm.
// RL3 - Torque from byte four, one percent steps.
// RL4 - Decode and keep the two-bit priority field.
// RL5 - Ignore conditions, undefined bits and bytes five-eight.
// RL6 - Sender repeats command at least every 30 ms.
// RL7 - After 30 ms silence, fall back to local.
// RL8 - Resume override at once on new commands.
// RL9 - Speed mode replaces every other speed demand.
// RL10 - No acceleration rate limit on override changes.
// RL11 - Limit mode clamps demand to requested limit.
// RL12 - Torque governing disables the speed limit function.
// RL13 - Sender ramps from broadcast desired speed.
// RL14 - Sender starts limit above demand, ramps release.
// RL15 - Accept destination zero from any source.
// RL16 - Only one controller sends override commands.
// RL17 - Mode zero command is an orderly release.
// RL18 - Node address fixed at zero, never changed.
// RL19 - Speed low byte first; torque offset 125.
`timescale 1ns/100ps
module estr_engine_rx
  import estr_pkg::*;
#(
  parameter int WDOG_LIMIT = WDOG_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  estr_if.engine           link,
  input  wire logic [15:0] local_speed,
  input  wire logic        rate_limited_en,
  input  wire logic [15:0] rate_limited_speed,
  input  wire logic        torque_governing,
  output logic [15:0]      governor_speed,
  output logic [7:0]       torque_demand,
  output logic             torque_valid,
  output logic [1:0]       ov_mode,
  output logic [1:0]       ov_prio,
  output logic [1:0]       ov_state,
  output logic [7:0]       node_addr,
  output logic             cmd_pulse,
  output logic             timeout_pulse,
  output logic             release_pulse
);
  logic [2:0]  idx_r;
  logic [2:0]  idx_nxt;
  logic        take_r;
  logic        take_nxt;
  logic [7:0]  b0_r;
  logic [7:0]  b0_nxt;
  logic [7:0]  b1_r;
  logic [7:0]  b1_nxt;
  logic [7:0]  b2_r;
  logic [7:0]  b2_nxt;
  logic [7:0]  b3_r;
  logic [7:0]  b3_nxt;
  logic [1:0]  mode_r;
  logic [1:0]  mode_nxt;
  logic [1:0]  prio_r;
  logic [1:0]  prio_nxt;
  logic [15:0] speed_r;
  logic [15:0] speed_nxt;
  logic [7:0]  torq_r;
  logic [7:0]  torq_nxt;
  logic [31:0] wd_r;
  logic [31:0] wd_nxt;
  estr_ov_e    ov_r;
  estr_ov_e    ov_nxt;
  logic        cmd_r;
  logic        cmd_nxt;
  logic        to_r;
  logic        to_nxt;
  logic        rel_r;
  logic        rel_nxt;
  logic [15:0] gov_r;
  logic [15:0] gov_nxt;
  logic        last;
  logic [15:0] base;
  logic [15:0] spd;

  // The receiver never stalls, since a MAC cannot hold a frame back.
  assign link.byte_ready = 1'b1;
  assign node_addr = NODE_ADDR; // RL18
  assign last = link.byte_valid && (idx_r == 3'(FRAME_BYTES - 1));

  always_comb begin
    idx_nxt = idx_r;
    take_nxt = take_r;
    b0_nxt = b0_r;
    b1_nxt = b1_r;
    b2_nxt = b2_r;
    b3_nxt = b3_r;
    mode_nxt = mode_r;
    prio_nxt = prio_r;
    speed_nxt = speed_r;
    torq_nxt = torq_r;
    cmd_nxt = 1'b0;
    to_nxt = 1'b0;
    rel_nxt = 1'b0;
    ov_nxt = ov_r;
    // The watchdog saturates so that a long silence cannot wrap into a
    // fresh window and hide the timeout.
    wd_nxt = (wd_r < WDOG_LIMIT) ? wd_r + 32'h1 : wd_r;
    if (link.frame_start) begin
      idx_nxt = 3'h0;
      // Any source may command; only the destination decides.
      take_nxt = (link.dest_addr == DEST_ENGINE); // RL15
    end else if (link.byte_valid) begin
      idx_nxt = idx_r + 3'h1;
      case (idx_r) // RL5
        3'h0: b0_nxt = link.byte_data;
        3'(SPEED_LO_BYTE): b1_nxt = link.byte_data;
        3'(SPEED_HI_BYTE): b2_nxt = link.byte_data;
        3'(TORQUE_BYTE): b3_nxt = link.byte_data;
        default: ;
      endcase
    end
    if (last && take_r) begin
      mode_nxt = b0_r[MODE_LSB +: 2]; // RL1
      prio_nxt = b0_r[PRIO_LSB +: 2]; // RL4
      speed_nxt = {b2_r, b1_r}; // RL2 RL19
      torq_nxt = b3_r; // RL3
      cmd_nxt = 1'b1;
      wd_nxt = WORD_RESET;
      // A release has its own state, so it is never mistaken for a lost link.
      if (b0_r[MODE_LSB +: 2] == ESTR_MODE_OFF) begin
        ov_nxt = ESTR_OV_RELEASE; // RL17
        rel_nxt = (ov_r == ESTR_OV_NET);
      end else begin
        ov_nxt = ESTR_OV_NET; // RL8
      end
    end else if (ov_r == ESTR_OV_NET && wd_r >= WDOG_LIMIT - 1) begin
      ov_nxt = ESTR_OV_TIMEOUT; // RL7
      to_nxt = 1'b1;
    end
  end

  // Out-of-range requests saturate rather than being dropped.
  assign spd = (speed_r > SPEED_MAX_RAW) ? SPEED_MAX_RAW : speed_r;
  // Override paths bypass the rate limited source.
  assign base = rate_limited_en ? rate_limited_speed : local_speed; // RL10

  always_comb begin
    gov_nxt = base;
    if (ov_r == ESTR_OV_NET) begin
      case (mode_r)
        ESTR_MODE_SPEED: gov_nxt = spd; // RL9 RL10
        // Limit mode caps the raw local demand, not the rate limited one.
        ESTR_MODE_LIMIT: begin
          if (!torque_governing && local_speed > spd) begin // RL11 RL12
            gov_nxt = spd;
          end else if (!torque_governing) begin
            gov_nxt = local_speed; // RL10
          end
        end
        default: gov_nxt = base;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= 3'h0;
      take_r <= 1'b0;
      b0_r <= BYTE_RESET;
      b1_r <= BYTE_RESET;
      b2_r <= BYTE_RESET;
      b3_r <= BYTE_RESET;
      mode_r <= ESTR_MODE_OFF;
      prio_r <= PRIO_RESET;
      speed_r <= SPEED_RESET;
      torq_r <= TORQUE_OFFSET;
      wd_r <= WORD_RESET;
      ov_r <= ESTR_OV_LOCAL;
      cmd_r <= 1'b0;
      to_r <= 1'b0;
      rel_r <= 1'b0;
      gov_r <= SPEED_RESET;
    end else begin
      idx_r <= idx_nxt;
      take_r <= take_nxt;
      b0_r <= b0_nxt;
      b1_r <= b1_nxt;
      b2_r <= b2_nxt;
      b3_r <= b3_nxt;
      mode_r <= mode_nxt;
      prio_r <= prio_nxt;
      speed_r <= speed_nxt;
      torq_r <= torq_nxt;
      wd_r <= wd_nxt;
      ov_r <= ov_nxt;
      cmd_r <= cmd_nxt;
      to_r <= to_nxt;
      rel_r <= rel_nxt;
      gov_r <= gov_nxt;
    end
  end

  assign governor_speed = gov_r;
  // Signed percent is raw minus 125, saturated to the valid range.
  assign torque_demand = (torq_r > TORQUE_MAX_RAW)
                         ? TORQUE_MAX_RAW - TORQUE_OFFSET
                         : torq_r - TORQUE_OFFSET; // RL19
  assign torque_valid = (ov_r == ESTR_OV_NET) &&
                        (mode_r == ESTR_MODE_TORQUE || mode_r == ESTR_MODE_LIMIT);
  assign ov_mode = mode_r;
  assign ov_prio = prio_r;
  assign ov_state = ov_r;
  assign cmd_pulse = cmd_r;
  assign timeout_pulse = to_r;
  assign release_pulse = rel_r;
endmodule

// >>> estr_cmd_tx.sv
// Commanding controller: APB registers build and send override frames.
// Assumes software re-triggers sends often enough to keep control.
`timescale 1ns/100ps
module estr_cmd_tx
  import estr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  estr_if.sender           link
);
  logic [1:0]  mode_r, mode_nxt, prio_r, prio_nxt;
  logic [15:0] spd_r, spd_nxt;
  logic [7:0]  trq_r, trq_nxt, src_r, src_nxt;
  logic [N_IRQ-1:0] st_r, st_nxt, ien_r, ien_nxt;
  logic        busy_r, busy_nxt, fs_r, fs_nxt, bv_r, bv_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic [7:0]  bd_r, bd_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic        wr, rd, done;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign done = bv_r && link.byte_ready && (idx_r == 3'(FRAME_BYTES - 1));

  always_comb begin
    {mode_nxt, prio_nxt, spd_nxt, trq_nxt, src_nxt} =
      {mode_r, prio_r, spd_r, trq_r, src_r};
    ien_nxt = ien_r;
    st_nxt = st_r;
    busy_nxt = busy_r;
    fs_nxt = 1'b0;
    bv_nxt = bv_r;
    idx_nxt = idx_r;
    bd_nxt = bd_r;
    rd_nxt = rd_r;
    if (wr) begin
      case (paddr)
        A_CTRL: begin
          mode_nxt = pwdata[CTRL_MODE +: 2]; // RL17
          prio_nxt = pwdata[CTRL_PRIO +: 2];
          if (pwdata[CTRL_SEND] && !busy_r) begin
            busy_nxt = 1'b1;
            fs_nxt = 1'b1;
          end
        end
        A_SPEED:  spd_nxt = pwdata[15:0]; // RL13 RL14
        A_TORQUE: trq_nxt = pwdata[7:0];
        A_IEN:    ien_nxt = pwdata[N_IRQ-1:0];
        A_ICLR:   st_nxt = st_r & ~pwdata[N_IRQ-1:0];
        A_SRC:    src_nxt = pwdata[7:0]; // RL16
        default: ;
      endcase
    end
    if (fs_r) begin
      bv_nxt = 1'b1;
      idx_nxt = 3'h0;
      bd_nxt = {2'h0, prio_r, 2'h0, mode_r};
    end else if (bv_r && link.byte_ready) begin
      idx_nxt = idx_r + 3'h1;
      case (idx_r + 3'h1)
        3'(SPEED_LO_BYTE): bd_nxt = spd_r[7:0];
        3'(SPEED_HI_BYTE): bd_nxt = spd_r[15:8];
        3'(TORQUE_BYTE):   bd_nxt = trq_r;
        default:           bd_nxt = 8'hFF;
      endcase
      if (done) begin
        bv_nxt = 1'b0;
        busy_nxt = 1'b0;
        st_nxt[ST_SENT] = 1'b1;
      end
    end
    rd_nxt = WORD_RESET;
    if (rd) begin
      case (paddr)
        A_CTRL:   rd_nxt = 32'({prio_r, mode_r, 1'b0});
        A_SPEED:  rd_nxt = 32'(spd_r);
        A_TORQUE: rd_nxt = 32'(trq_r);
        A_STAT:   rd_nxt = 32'({busy_r, st_r});
        A_IEN:    rd_nxt = 32'(ien_r);
        A_SRC:    rd_nxt = 32'(src_r);
        default:  rd_nxt = WORD_RESET;
      endcase
    end else if (psel && penable) begin
      rd_nxt = rd_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= ESTR_MODE_OFF;
      prio_r <= PRIO_RESET;
      spd_r <= SPEED_RESET;
      trq_r <= TORQUE_OFFSET;
      src_r <= BYTE_RESET;
      ien_r <= '0;
      st_r <= '0;
      busy_r <= 1'b0;
      fs_r <= 1'b0;
      bv_r <= 1'b0;
      idx_r <= 3'h0;
      bd_r <= BYTE_RESET;
      rd_r <= WORD_RESET;
    end else begin
      mode_r <= mode_nxt;
      prio_r <= prio_nxt;
      spd_r <= spd_nxt;
      trq_r <= trq_nxt;
      src_r <= src_nxt;
      ien_r <= ien_nxt;
      st_r <= st_nxt;
      busy_r <= busy_nxt;
      fs_r <= fs_nxt;
      bv_r <= bv_nxt;
      idx_r <= idx_nxt;
      bd_r <= bd_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign prdata = rd_r;
  assign irq = |(st_r & ien_r);
  assign link.frame_start = fs_r;
  assign link.byte_valid = bv_r;
  assign link.byte_data = bd_r;
  assign link.dest_addr = DEST_ENGINE;
  assign link.src_addr = src_r;
endmodule

// >>> estr_link_assertions.sv
// Checker for the override command link between the two ends.
// Assumes one pclk domain; it sees only the interface signals.
`timescale 1ns/100ps
module estr_link_assertions
  import estr_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       frame_start,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [7:0] dest_addr,
  input wire logic [7:0] src_addr,
  input wire logic       byte_ready
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Starts at eight so the first frame after reset counts as preceded by
  // a whole one.
  always_comb begin
    cnt_nxt = cnt_r;
    if (frame_start) begin
      cnt_nxt = 4'h0;
    end else if (byte_valid) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h8;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_ready_high: assert property (byte_ready)
    else $error("engine not ready");
  a_dest_engine: assert property (
    frame_start |-> dest_addr == DEST_ENGINE)
    else $error("frame not sent to the engine");
  a_frame_bytes: assert property (
    frame_start |=> byte_valid [*8])
    else $error("frame bytes not contiguous");
  a_frame_end: assert property (
    frame_start ##1 byte_valid [*8] |=> !byte_valid)
    else $error("frame longer than eight bytes");
  a_start_idle: assert property (frame_start |-> !byte_valid)
    else $error("byte during frame start");
  a_valid_started: assert property (
    $rose(byte_valid) |-> $past(frame_start))
    else $error("bytes without frame start");
  a_whole_frame: assert property (frame_start |-> cnt_r == 4'h8)
    else $error("previous frame cut short");
  a_byte_in_frame: assert property (byte_valid |-> cnt_r < 4'h8)
    else $error("byte beyond frame end");

  c_speed_cmd: cover property (
    frame_start ##1 byte_valid && byte_data[1:0] == 2'b01);
  c_limit_cmd: cover property (
    frame_start ##1 byte_valid && byte_data[1:0] == 2'b11);
  c_release_cmd: cover property (
    frame_start ##1 byte_valid && byte_data[1:0] == 2'b00);
endmodule

// >>> testbench.sv
// Bench joining the commanding controller to the engine receiver.
// Assumes a 125 MHz pclk; a second receiver is fed by the bench itself.
`timescale 1ns/100ps
module testbench
  import estr_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, tg, rle, cp, tp, rp, tv;
  logic [7:0]  paddr, td, td2, na;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] ls, gs, gs2;
  logic [1:0]  om, op, os, om2, op2, os2;
  logic [7:0]  cap [8];
  int          bad_count, checks_done, idx;

  estr_if l1();
  estr_if l2();
  estr_cmd_tx estr_cmd_tx_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(l1.sender));
  estr_engine_rx #(.WDOG_LIMIT(200)) estr_engine_rx_i (.pclk(pclk),
    .presetn(presetn), .link(l1.engine), .local_speed(ls),
    .rate_limited_en(rle), .rate_limited_speed(16'h0040),
    .torque_governing(tg), .governor_speed(gs), .torque_demand(td),
    .torque_valid(tv), .ov_mode(om), .ov_prio(op), .ov_state(os),
    .node_addr(na), .cmd_pulse(cp), .timeout_pulse(tp), .release_pulse(rp));
  estr_engine_rx #(.WDOG_LIMIT(200)) estr_engine_rx_i2 (.pclk(pclk),
    .presetn(presetn), .link(l2.engine), .local_speed(ls),
    .rate_limited_en(rle), .rate_limited_speed(16'h0000),
    .torque_governing(tg), .governor_speed(gs2), .torque_demand(td2),
    .torque_valid(), .ov_mode(om2), .ov_prio(op2), .ov_state(os2),
    .node_addr(), .cmd_pulse(), .timeout_pulse(), .release_pulse());
  estr_link_assertions estr_link_assertions_i (.pclk(pclk),
    .presetn(presetn), .frame_start(l1.frame_start),
    .byte_valid(l1.byte_valid), .byte_data(l1.byte_data),
    .dest_addr(l1.dest_addr), .src_addr(l1.src_addr),
    .byte_ready(l1.byte_ready));

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    if (l1.frame_start) begin
      idx = 0;
    end else if (l1.byte_valid && idx < 8) begin
      cap[idx] = l1.byte_data;
      idx++;
    end
  end

  task end_sim;
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  task stall(input string m);
    chk(0, 1, m);
    end_sim;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) stall("no pready");
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task wait_ev(input int k, output int n);
    logic s;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      s = (k == 0) ? cp : (k == 1) ? tp : rp;
    end while (s !== 1'b1 && n < 1000);
    if (s !== 1'b1) stall("no pulse");
  endtask

  task send(input logic [1:0] m, p, input logic [15:0] s, input logic [7:0] t);
    int n;
    apb(1'b1, A_SPEED, {16'h0000, s});
    apb(1'b1, A_TORQUE, {24'h000000, t});
    apb(1'b1, A_CTRL, {27'h0, p, m, 1'b1});
    wait_ev(0, n);
    repeat (2) @(negedge pclk);
  endtask

  task frame2(input logic [7:0] d, input logic [63:0] b);
    @(posedge pclk);
    l2.frame_start <= 1'b1;
    l2.dest_addr <= d;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      l2.frame_start <= 1'b0;
      l2.byte_valid <= 1'b1;
      l2.byte_data <= b[8*i +: 8];
    end
    @(posedge pclk);
    l2.byte_valid <= 1'b0;
    l2.byte_data <= ~b[63:56];
    l2.dest_addr <= ~d;
    repeat (3) @(negedge pclk);
  endtask

  task t_reset;
    chk(os, ESTR_OV_LOCAL, "state");
    chk(op, PRIO_RESET, "prio");
    chk(na, NODE_ADDR, "node");
    chk(irq, 0, "irq");
    apb(1'b0, A_TORQUE, 0);
    chk(q, TORQUE_OFFSET, "torque reg");
    $display("reset test done");
  endtask

  task t_speed;
    @(posedge pclk);
    rle <= 1'b1;
    apb(1'b1, A_IEN, 1);
    chk(gs, 16'h0040, "rate src");
    send(ESTR_MODE_SPEED, 2'h2, 16'h1234, 8'h91);
    chk(cap[1], 8'h34, "low byte");
    chk(cap[2], 8'h12, "high byte");
    chk(cap[0][1:0], 2'h1, "mode bits");
    chk(cap[0][5:4], 2'h2, "prio bits");
    chk(os, ESTR_OV_NET, "state");
    chk(gs, 16'h1234, "speed");
    chk(td, 8'h14, "torque");
    chk(op, 2'h2, "prio");
    chk(tv, 0, "no torque");
    chk(irq, 1, "irq set");
    apb(1'b1, A_ICLR, 1);
    apb(1'b0, A_STAT, 0);
    chk(q[ST_SENT], 0, "clear");
    chk(irq, 0, "irq clear");
    apb(1'b1, A_IEN, 0);
    send(ESTR_MODE_SPEED, 2'h2, 16'hFFFF, 8'h91);
    chk(gs, SPEED_MAX_RAW, "clamp");
    apb(1'b0, A_STAT, 0);
    chk({q[ST_SENT], irq}, 2'b10, "mask");
    apb(1'b0, 8'h1C, 0);
    chk(q, 0, "unmapped");
    chk(pslverr, 0, "no error");
    @(posedge pclk);
    rle <= 1'b0;
    $display("speed test done");
  endtask

  task t_limit;
    @(posedge pclk);
    ls <= 16'h1000;
    send(ESTR_MODE_LIMIT, 2'h1, 16'h0800, 8'h7D);
    chk(gs, 16'h0800, "limit");
    chk({om, tv}, {ESTR_MODE_LIMIT, 1'b1}, "limit mode");
    @(posedge pclk);
    tg <= 1'b1;
    repeat (3) @(negedge pclk);
    chk(gs, 16'h1000, "torque gov");
    @(posedge pclk);
    tg <= 1'b0;
    ls <= 16'h0400;
    repeat (3) @(negedge pclk);
    chk(gs, 16'h0400, "below limit");
    $display("limit test done");
  endtask

  task t_timeout;
    int n;
    send(ESTR_MODE_SPEED, 2'h0, 16'h0200, 8'h7D);
    wait_ev(1, n);
    chk(n >= 194 && n <= 202, 1, "timeout time");
    chk(os, ESTR_OV_TIMEOUT, "timeout");
    repeat (2) @(negedge pclk);
    chk(gs, 16'h0400, "local");
    send(ESTR_MODE_SPEED, 2'h0, 16'h0300, 8'h7D);
    chk({os, gs}, {ESTR_OV_NET, 16'h0300}, "resume");
    $display("timeout test done");
  endtask

  task t_release;
    int n;
    apb(1'b1, A_CTRL, {27'h0, 2'h0, ESTR_MODE_OFF, 1'b1});
    wait_ev(2, n);
    chk(os, ESTR_OV_RELEASE, "release");
    repeat (2) @(negedge pclk);
    chk(gs, 16'h0400, "local");
    $display("release test done");
  endtask

  task t_foreign;
    frame2(8'h05, 64'h0000_0000_0000_0001);
    chk(os2, ESTR_OV_LOCAL, "other dest");
    frame2(DEST_ENGINE, 64'hFFFF_FFFF_0004_56CE);
    chk({om2, os2}, {ESTR_MODE_TORQUE, ESTR_OV_NET}, "torque");
    chk(op2, 2'h0, "prio");
    chk({td2, gs2}, {8'h83, 16'h0400}, "values");
    $display("foreign test done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, tg, rle} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ls = 16'h0100;
    {l2.frame_start, l2.byte_valid} = 2'b00;
    {l2.byte_data, l2.dest_addr, l2.src_addr} = 24'h000077;
    bad_count = 0;
    checks_done = 0;
    idx = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset;
    t_speed;
    t_limit;
    t_timeout;
    t_release;
    t_foreign;
    end_sim;
  end
endmodule
